/* include/smcs_pkg.sv */
// constants and types for the servo monitor and comm supervisor
package smcs_pkg;

	localparam int unsigned CLK_HZ          = 10_000_000;
	localparam int unsigned REPLY_DELAY_US  = 400;
	localparam int unsigned REPLY_CYC       = REPLY_DELAY_US * (CLK_HZ / 1_000_000);
	localparam int unsigned SEC_CYC         = CLK_HZ;

	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_MON     = 8'h04;
	localparam logic [7:0] ADDR_OFS1    = 8'h08;
	localparam logic [7:0] ADDR_OFS2    = 8'h0c;
	localparam logic [7:0] ADDR_COMM    = 8'h10;
	localparam logic [7:0] ADDR_LIMP    = 8'h14;
	localparam logic [7:0] ADDR_LIMN    = 8'h18;
	localparam logic [7:0] ADDR_STAT    = 8'h1c;
	localparam logic [7:0] ADDR_IRQ     = 8'h20;
	localparam logic [7:0] ADDR_MASK    = 8'h24;
	localparam logic [7:0] ADDR_ALMCUR  = 8'h28;
	localparam logic [7:0] ADDR_ALMPAST = 8'h2c;

	localparam logic [7:0] MON_RESET    = 8'h10;
	localparam logic [3:0] SEL_MAX      = 4'ha;
	localparam logic [7:0] ALM_NONE     = 8'h00;
	localparam int         HIST_DEPTH   = 5;

	localparam logic signed [10:0] OFS_MAX = 11'sd999;
	localparam logic signed [10:0] OFS_MIN = -11'sd999;
	localparam logic signed [15:0] MV_8V   = 16'sd8000;
	localparam logic signed [15:0] MV_10V  = 16'sd10000;
	localparam logic [5:0]         TMO_MAX = 6'd60;

	localparam int IRQ_W        = 4;
	localparam int IRQ_LIMIT    = 0;
	localparam int IRQ_TIMEOUT  = 1;
	localparam int IRQ_ALARM    = 2;
	localparam int IRQ_REPLY    = 3;

	typedef enum logic [1:0] {
		SMCS_IDLE  = 2'b00,
		SMCS_WAIT  = 2'b01,
		SMCS_SEND  = 2'b10
	} smcs_reply_t;

	typedef struct packed {
		logic [5:0] timeout_s;
		logic       reply_delay;
		logic       use_rs232;
		logic       no_checksum;
	} smcs_comm_t;

	typedef struct packed {
		logic signed [15:0] speed;
		logic signed [15:0] cmd_speed;
		logic signed [15:0] torque;
		logic signed [15:0] cur_cmd;
		logic signed [31:0] droop;
	} smcs_feed_t;

endpackage : smcs_pkg

/* hdl/smcs_mon_chan.sv */
// one analog monitor channel: source select, scaling and offset
`timescale 1ns/1ps
`default_nettype none
module smcs_mon_chan
	import smcs_pkg::*;
(
	input  wire logic               clk_sys,
	input  wire logic               rst_n,
	input  wire logic [3:0]         sel,
	input  wire logic signed [10:0] ofs_mv,
	input  wire smcs_feed_t         feed,
	output logic signed [15:0]      out_mv
);

	logic signed [47:0] scaled;
	logic signed [47:0] prod;
	logic signed [47:0] next_mv;

	// full scale inputs are +-32767, droop ranges shift by log2 of the range
	always_comb begin
		prod   = '0;
		scaled = '0;
		unique case (sel)
			4'h0: prod = 48'(feed.speed) * 48'(MV_8V);
			4'h2: prod = 48'(feed.speed) * 48'(MV_8V);
			4'h5: prod = 48'(feed.cmd_speed) * 48'(MV_8V);
			4'h1: prod = 48'(feed.torque) * 48'(MV_8V);
			4'h3: prod = 48'(feed.torque) * 48'(MV_8V);
			4'h4: prod = 48'(feed.cur_cmd) * 48'(MV_8V);
			default: prod = 48'(feed.droop) * 48'(MV_10V);
		endcase
		unique case (sel)
			4'h6: scaled = prod >>> 7;
			4'h7: scaled = prod >>> 11;
			4'h8: scaled = prod >>> 13;
			4'h9: scaled = prod >>> 15;
			4'ha: scaled = prod >>> 17;
			default: scaled = prod >>> 15;
		endcase
		next_mv = scaled + 48'(ofs_mv);
		// clamp so droop overrange saturates rather than wraps
		if (next_mv > 48'sd10999)
			next_mv = 48'sd10999;
		else if (next_mv < -48'sd10999)
			next_mv = -48'sd10999;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			out_mv <= '0;
		else
			out_mv <= next_mv[15:0];
	end

endmodule : smcs_mon_chan
`default_nettype wire

/* hdl/smcs_top.sv */
// servo monitor, stop pattern, alarm history and comm supervisor
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module smcs_top
	import smcs_pkg::*;
#(
	parameter int unsigned SEC_CYCLES   = SEC_CYC,
	parameter int unsigned REPLY_CYCLES = REPLY_CYC
)(
	input  wire logic               clk_sys,
	input  wire logic               rst_n,
	input  wire logic [7:0]         reg_addr,
	input  wire logic [31:0]        reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic [31:0]             reg_rdata,
	input  wire smcs_feed_t         feed,
	input  wire logic signed [31:0] cur_pos,
	input  wire logic               homing,
	input  wire logic               lsp_hit,
	input  wire logic               lsn_hit,
	input  wire logic               alarm_new,
	input  wire logic [7:0]         alarm_code,
	input  wire logic               frame_ok,
	input  wire logic               tx_done,
	output logic                    reply_go,
	output logic                    reply_cksum,
	output logic                    rs485_en,
	output logic                    rs232_en,
	output logic                    droop_clear,
	output logic                    droop_drain,
	output logic                    motor_stop,
	output logic signed [15:0]      mon1_mv,
	output logic signed [15:0]      mon2_mv,
	output logic                    irq
);

	////////////////////////////////////////////////////////////////////////
	// configuration registers

	logic [7:0]         mon_sel;
	logic signed [10:0] ofs1;
	logic signed [10:0] ofs2;
	smcs_comm_t         comm;
	logic               slow_stop;
	logic signed [31:0] lim_pos;
	logic signed [31:0] lim_neg;
	logic [IRQ_W-1:0]   irq_stat;
	logic [IRQ_W-1:0]   irq_mask;
	logic [IRQ_W-1:0]   irq_evt;
	logic [7:0]         alm_cur;
	logic [7:0]         alm_past [HIST_DEPTH];
	logic               hist_clr;

	function automatic logic signed [10:0] clip_ofs(input logic [31:0] v);
		logic signed [31:0] s;
		s = $signed(v);
		if (s > 32'(OFS_MAX))
			return OFS_MAX;
		if (s < 32'(OFS_MIN))
			return OFS_MIN;
		return s[10:0];
	endfunction : clip_ofs

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mon_sel   <= MON_RESET;
			ofs1      <= '0;
			ofs2      <= '0;
			comm      <= '0;
			slow_stop <= 1'b0;
			lim_pos   <= '0;
			lim_neg   <= '0;
			irq_mask  <= '0;
		end else if (reg_wr) begin
			unique case (reg_addr)
				ADDR_CTRL: slow_stop <= reg_wdata[0];
				ADDR_MON: begin
					// codes above A are kept out, so a channel never idles
					if (reg_wdata[3:0] <= SEL_MAX)
						mon_sel[3:0] <= reg_wdata[3:0];
					if (reg_wdata[7:4] <= SEL_MAX)
						mon_sel[7:4] <= reg_wdata[7:4];
				end
				ADDR_OFS1: ofs1 <= clip_ofs(reg_wdata);
				ADDR_OFS2: ofs2 <= clip_ofs(reg_wdata);
				ADDR_COMM: begin
					comm.no_checksum <= reg_wdata[0];
					comm.use_rs232   <= reg_wdata[1];
					comm.reply_delay <= reg_wdata[2];
					comm.timeout_s   <= (reg_wdata[13:8] > TMO_MAX) ? TMO_MAX : reg_wdata[13:8];
				end
				ADDR_LIMP: lim_pos  <= $signed(reg_wdata);
				ADDR_LIMN: lim_neg  <= $signed(reg_wdata);
				ADDR_MASK: irq_mask <= reg_wdata[IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	assign hist_clr = reg_wr && (reg_addr == ADDR_CTRL) && reg_wdata[1];

	////////////////////////////////////////////////////////////////////////
	// analog monitors

	smcs_mon_chan u_ch1 (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.sel     (mon_sel[3:0]),
		.ofs_mv  (ofs1),
		.feed    (feed),
		.out_mv  (mon1_mv)
	);

	smcs_mon_chan u_ch2 (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.sel     (mon_sel[7:4]),
		.ofs_mv  (ofs2),
		.feed    (feed),
		.out_mv  (mon2_mv)
	);

	////////////////////////////////////////////////////////////////////////
	// software limit and stop pattern

	logic soft_lim_on;
	logic soft_hit;
	logic limit_any;
	logic limit_prev;
	logic tmo_fault;

	assign soft_lim_on = (lim_pos != lim_neg) && !homing;
	assign soft_hit    = soft_lim_on && ((cur_pos > lim_pos) || (cur_pos < lim_neg));
	assign limit_any   = lsp_hit || lsn_hit || soft_hit;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			droop_clear <= 1'b0;
			droop_drain <= 1'b0;
			motor_stop  <= 1'b0;
			limit_prev  <= 1'b0;
		end else begin
			limit_prev  <= limit_any;
			// clear fires once on the rising limit edge; drain holds while active
			droop_clear <= limit_any && !limit_prev && !slow_stop;
			droop_drain <= limit_any && slow_stop;
			motor_stop  <= limit_any || tmo_fault;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// serial interface choice and reply timing

	smcs_reply_t        rstate;
	logic [31:0]        rcnt;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rs485_en <= 1'b0;
			rs232_en <= 1'b0;
		end else begin
			rs485_en <= !comm.use_rs232;
			rs232_en <= comm.use_rs232;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			reply_cksum <= 1'b1;
		else
			reply_cksum <= !comm.no_checksum;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rstate   <= SMCS_IDLE;
			rcnt     <= '0;
			reply_go <= 1'b0;
		end else begin
			reply_go <= 1'b0;
			unique case (rstate)
				SMCS_IDLE: if (frame_ok) begin
					rcnt <= '0;
					// delay off answers at once, well inside the bound
					rstate <= comm.reply_delay ? SMCS_WAIT : SMCS_SEND;
				end
				SMCS_WAIT: begin
					rcnt <= rcnt + 32'd1;
					if (rcnt >= REPLY_CYCLES - 1)
						rstate <= SMCS_SEND;
				end
				SMCS_SEND: begin
					reply_go <= 1'b1;
					rstate   <= SMCS_IDLE;
				end
				default: rstate <= SMCS_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// communication time-out

	logic [31:0] sec_cnt;
	logic        sec_tick;
	logic [5:0]  idle_s;

	assign sec_tick = (sec_cnt == SEC_CYCLES - 1);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			sec_cnt <= '0;
		else if (frame_ok || sec_tick)
			sec_cnt <= '0;
		else
			sec_cnt <= sec_cnt + 32'd1;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			idle_s    <= '0;
			tmo_fault <= 1'b0;
		end else if (frame_ok || comm.timeout_s == '0) begin
			idle_s    <= '0;
			tmo_fault <= 1'b0;
		end else if (sec_tick && !tmo_fault) begin
			idle_s <= idle_s + 6'd1;
			if (idle_s + 6'd1 >= comm.timeout_s)
				tmo_fault <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// alarm history

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			alm_cur <= ALM_NONE;
			for (int i = 0; i < HIST_DEPTH; i++)
				alm_past[i] <= ALM_NONE;
		end else if (alarm_new) begin
			// a new alarm beats a same-cycle clear so it is never lost
			alm_cur     <= alarm_code;
			alm_past[0] <= hist_clr ? ALM_NONE : alm_cur;
			for (int i = 1; i < HIST_DEPTH; i++)
				alm_past[i] <= hist_clr ? ALM_NONE : alm_past[i-1];
		end else if (hist_clr) begin
			alm_cur <= ALM_NONE;
			for (int i = 0; i < HIST_DEPTH; i++)
				alm_past[i] <= ALM_NONE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupts

	logic tmo_prev;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			tmo_prev <= 1'b0;
		else
			tmo_prev <= tmo_fault;
	end

	always_comb begin
		irq_evt = '0;
		irq_evt[IRQ_LIMIT]   = limit_any && !limit_prev;
		irq_evt[IRQ_TIMEOUT] = tmo_fault && !tmo_prev;
		irq_evt[IRQ_ALARM]   = alarm_new;
		irq_evt[IRQ_REPLY]   = tx_done;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			irq_stat <= '0;
		else if (reg_wr && reg_addr == ADDR_IRQ)
			irq_stat <= (irq_stat & ~reg_wdata[IRQ_W-1:0]) | irq_evt;
		else
			irq_stat <= irq_stat | irq_evt;
	end

	assign irq = |(irq_stat & irq_mask);

	////////////////////////////////////////////////////////////////////////
	// register read

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			reg_rdata <= '0;
		else if (reg_rd) begin
			unique case (reg_addr)
				ADDR_CTRL:    reg_rdata <= {31'h0, slow_stop};
				ADDR_MON:     reg_rdata <= {24'h0, mon_sel};
				ADDR_OFS1:    reg_rdata <= 32'(ofs1);
				ADDR_OFS2:    reg_rdata <= 32'(ofs2);
				ADDR_COMM:    reg_rdata <= {18'h0, comm.timeout_s, 5'h0, comm.reply_delay,
				                            comm.use_rs232, comm.no_checksum};
				ADDR_LIMP:    reg_rdata <= lim_pos;
				ADDR_LIMN:    reg_rdata <= lim_neg;
				ADDR_STAT:    reg_rdata <= {27'h0, homing, soft_lim_on, tmo_fault,
				                            motor_stop, limit_any};
				ADDR_IRQ:     reg_rdata <= {28'h0, irq_stat};
				ADDR_MASK:    reg_rdata <= {28'h0, irq_mask};
				ADDR_ALMCUR:  reg_rdata <= {24'h0, alm_cur};
				ADDR_ALMPAST: reg_rdata <= {alm_past[3], alm_past[2],
				                            alm_past[1], alm_past[0]};
				ADDR_ALMPAST + 8'h04: reg_rdata <= {24'h0, alm_past[4]};
				default:      reg_rdata <= '0;
			endcase
		end else
			reg_rdata <= '0;
	end

endmodule : smcs_top
`default_nettype wire

/* verification/smcs_chk.sv */
// port checker for the servo monitor and comm supervisor
`timescale 1ns/1ps
`default_nettype none
module smcs_chk
	import smcs_pkg::*;
#(
	parameter int unsigned REPLY_CYCLES = REPLY_CYC
)(
	input wire logic               clk_sys,
	input wire logic               rst_n,
	input wire logic [7:0]         reg_addr,
	input wire logic [31:0]        reg_wdata,
	input wire logic               reg_wr,
	input wire logic               reg_rd,
	input wire logic [31:0]        reg_rdata,
	input wire logic               lsp_hit,
	input wire logic               lsn_hit,
	input wire logic               frame_ok,
	input wire logic               reply_go,
	input wire logic               reply_cksum,
	input wire logic               rs485_en,
	input wire logic               rs232_en,
	input wire logic               droop_clear,
	input wire logic               droop_drain,
	input wire logic               motor_stop,
	input wire logic signed [15:0] mon1_mv,
	input wire logic signed [15:0] mon2_mv
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic slow;
	logic dly;
	////////////////////////////////////////////////////////////////
	// shadow copies of the settings, taken from the register bus
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			slow <= 1'b0;
		end else if (reg_wr && reg_addr == ADDR_CTRL) begin
			slow <= reg_wdata[0];
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dly <= 1'b0;
		end else if (reg_wr && reg_addr == ADDR_COMM) begin
			dly <= reg_wdata[2];
		end
	end
	////////////////////////////////////////////////////////////////
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data not zero outside read cycle");
	a_reply_fast: assert property (reply_go && !dly |-> $past(frame_ok, 2))
		else $error("fast reply not two cycles after frame");
	a_reply_slow: assert property (reply_go && dly |-> $past(frame_ok, REPLY_CYCLES + 2))
		else $error("delayed reply at wrong cycle");
	// setting lands in comm at the write edge, the pins follow one edge later
	a_cksum_set: assert property (reg_wr && reg_addr == ADDR_COMM |->
		##2 reply_cksum == !$past(reg_wdata[0], 2))
		else $error("checksum flag does not follow setting");
	a_port_sel: assert property (reg_wr && reg_addr == ADDR_COMM |->
		##2 rs232_en == $past(reg_wdata[1], 2))
		else $error("serial standard does not follow setting");
	a_port_one: assert property ($past(rst_n) |-> rs485_en ^ rs232_en)
		else $error("not exactly one serial standard enabled");
	a_limit_stop: assert property (lsp_hit || lsn_hit |=> motor_stop)
		else $error("limit switch did not stop motor");
	a_slow_drain: assert property ((lsp_hit || lsn_hit) && slow |=> droop_drain && !droop_clear)
		else $error("slow stop did not drain droop");
	a_sudden_clr: assert property (droop_clear |-> !slow && motor_stop)
		else $error("droop clear outside sudden stop");
	a_mon_range: assert property (mon1_mv <= 16'sd10999 && mon1_mv >= -16'sd10999 &&
		mon2_mv <= 16'sd10999 && mon2_mv >= -16'sd10999)
		else $error("monitor output beyond range");
	c_reply_slow: cover property (reply_go && dly);
	c_drain: cover property (droop_drain);
	c_clear: cover property (droop_clear);
endmodule : smcs_chk
`default_nettype wire

/* verification/smcs_master.sv */
// master station model: sends frames, takes replies
`timescale 1ns/1ps
`default_nettype none
module smcs_master (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       reply_go,
	input  wire logic [2:0] lat,
	output logic            frame_ok,
	output logic            tx_done
);
	logic [3:0] cnt;
	initial frame_ok = 1'b0;
	task automatic send();
		@(posedge clk_sys);
		frame_ok <= 1'b1;
		@(posedge clk_sys);
		frame_ok <= 1'b0;
	endtask : send
	// reply length at the agreed rate, varied to get prompt and slow ends
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt     <= 4'h0;
			tx_done <= 1'b0;
		end else begin
			cnt     <= reply_go ? {1'b0, lat} + 4'h1 : (cnt != 4'h0 ? cnt - 4'h1 : cnt);
			tx_done <= cnt == 4'h1;
		end
	end
endmodule : smcs_master
`default_nettype wire

/* verification/tb.sv */
// self-checking bench of the servo monitor and comm supervisor
`timescale 1ns/1ps
`default_nettype none
module tb
	import smcs_pkg::*;
;
	localparam int unsigned RPL = 8;
	logic               clk_sys     = 1'b0;
	logic               rst_n       = 1'b0;
	logic [7:0]         reg_addr    = 8'h00;
	logic [31:0]        reg_wdata   = 32'h0;
	logic               reg_wr      = 1'b0;
	logic               reg_rd      = 1'b0;
	logic [31:0]        reg_rdata;
	smcs_feed_t         feed        = '{16'sd20000, 16'sd0, -16'sd12000, 16'sd0, 32'sd0};
	logic signed [31:0] cur_pos     = 32'sh0;
	logic               homing      = 1'b0;
	logic               lsp_hit     = 1'b0;
	logic               lsn_hit     = 1'b0;
	logic               alarm_new   = 1'b0;
	logic [7:0]         alarm_code  = 8'h00;
	logic [2:0]         lat         = 3'h0;
	logic               frame_ok, tx_done, reply_go, reply_cksum, rs485_en, rs232_en, irq;
	logic               droop_clear, droop_drain, motor_stop;
	logic signed [15:0] mon1_mv, mon2_mv;
	int                 miscompares = 0;
	int                 comparisons = 0;
	int                 cycles      = 0;
	int                 n, o1, o2;
	logic [3:0]         s2;
	logic [7:0]         al [7];
	always #50 clk_sys = ~clk_sys;
	smcs_top #(.SEC_CYCLES(20), .REPLY_CYCLES(RPL)) i_dut (.clk_sys, .rst_n, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .feed, .cur_pos, .homing, .lsp_hit,
		.lsn_hit, .alarm_new, .alarm_code, .frame_ok, .tx_done, .reply_go, .reply_cksum,
		.rs485_en, .rs232_en, .droop_clear, .droop_drain, .motor_stop, .mon1_mv,
		.mon2_mv, .irq);
	smcs_master i_master (.clk_sys, .rst_n, .reply_go, .lat, .frame_ok, .tx_done);
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#10 chk(reg_rdata, e);
	endtask : rd
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
		#10;
	endtask : cyc
	function automatic logic signed [15:0] exp_mon(input logic [3:0] s, input int o);
		longint v;
		int     k [5] = '{7, 11, 13, 15, 17};
		case (s)
			4'h0, 4'h2: v = longint'(feed.speed) * 8000 >>> 15;
			4'h5:       v = longint'(feed.cmd_speed) * 8000 >>> 15;
			4'h1, 4'h3: v = longint'(feed.torque) * 8000 >>> 15;
			4'h4:       v = longint'(feed.cur_cmd) * 8000 >>> 15;
			default:    v = longint'(feed.droop) * 10000 >>> k[s - 4'h6];
		endcase
		v = v + (o > 999 ? 999 : (o < -999 ? -999 : o));
		return 16'(v > 10999 ? 10999 : (v < -10999 ? -10999 : v));
	endfunction : exp_mon
	task automatic stop_test();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test
	// ceiling well above the few hundred cycles the tests need
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			stop_test();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(22));
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		cyc(2);
		chk(mon1_mv, exp_mon(4'h0, 0));
		chk(mon2_mv, exp_mon(4'h1, 0));
		chk({rs485_en, rs232_en, reply_cksum}, 3'b101);
		rd(ADDR_MON, 32'h10);
		rd(8'h40, 32'h0);
		$display("test reset done");
		for (int i = 0; i <= 10; i++) begin
			s2 = 4'($urandom_range(10));
			o1 = int'($urandom_range(2046)) - 1023;
			o2 = int'($urandom_range(2046)) - 1023;
			@(posedge clk_sys);
			feed <= {16'($urandom), 16'($urandom), 16'($urandom), 16'($urandom),
				32'($signed(20'($urandom)))};
			wr(ADDR_MON, {24'h0, s2, 4'(i)});
			wr(ADDR_OFS1, o1);
			wr(ADDR_OFS2, o2);
			cyc(2);
			chk(mon1_mv, exp_mon(4'(i), o1));
			chk(mon2_mv, exp_mon(s2, o2));
		end
		$display("test monitor done");
		wr(ADDR_CTRL, 32'h0);
		@(posedge clk_sys) lsp_hit <= 1'b1;
		cyc(1);
		chk({droop_clear, motor_stop}, 2'b11);
		cyc(1);
		chk(droop_clear, 1'b0);
		@(posedge clk_sys) lsp_hit <= 1'b0;
		wr(ADDR_CTRL, 32'h1);
		@(posedge clk_sys) lsn_hit <= 1'b1;
		cyc(2);
		chk({droop_drain, droop_clear}, 2'b10);
		@(posedge clk_sys) lsn_hit <= 1'b0;
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_LIMP, 32'd100);
		wr(ADDR_LIMN, -32'sd100);
		@(posedge clk_sys) cur_pos <= 32'sd200;
		cyc(2);
		chk(motor_stop, 1'b1);
		@(posedge clk_sys) homing <= 1'b1;
		cyc(2);
		chk(motor_stop, 1'b0);
		@(posedge clk_sys) homing <= 1'b0;
		wr(ADDR_LIMN, 32'd100);
		cyc(2);
		chk(motor_stop, 1'b0);
		@(posedge clk_sys) cur_pos <= 32'sd0;
		$display("test limits done");
		wr(ADDR_MASK, 32'h0);
		for (int j = 0; j < 7; j++) begin
			al[j] = 8'($urandom_range(255, 1));
			@(posedge clk_sys);
			alarm_new  <= 1'b1;
			alarm_code <= al[j];
			@(posedge clk_sys);
			alarm_new <= 1'b0;
		end
		cyc(1);
		chk(irq, 1'b0);
		wr(ADDR_MASK, 32'h4);
		cyc(1);
		chk(irq, 1'b1);
		rd(ADDR_ALMCUR, {24'h0, al[6]});
		rd(ADDR_ALMPAST, {al[2], al[3], al[4], al[5]});
		rd(8'h30, {24'h0, al[1]});
		wr(ADDR_IRQ, 32'h4);
		cyc(1);
		chk(irq, 1'b0);
		wr(ADDR_CTRL, 32'h2);
		rd(ADDR_ALMCUR, 32'h0);
		rd(ADDR_ALMPAST, 32'h0);
		$display("test alarms done");
		for (int m = 0; m < 8; m++) begin
			wr(ADDR_COMM, 32'(m));
			cyc(1);
			chk({reply_cksum, rs232_en, rs485_en}, {!m[0], m[1], !m[1]});
			lat <= 3'($urandom);
			i_master.send();
			n = 0;
			do begin
				@(negedge clk_sys);
				n++;
			end while (!reply_go && n < 50);
			chk(n, m[2] ? RPL + 2 : 2);
			cyc(12);
		end
		$display("test comm done");
		wr(ADDR_COMM, 32'h200);
		i_master.send();
		cyc(30);
		chk(motor_stop, 1'b0);
		i_master.send();
		cyc(30);
		chk(motor_stop, 1'b0);
		cyc(15);
		chk(motor_stop, 1'b1);
		// status: time-out fault and stop, soft limit off since both limits are equal
		rd(ADDR_STAT, 32'h6);
		// sticky events: limit rise, time-out, reply sent; alarm bit was cleared
		rd(ADDR_IRQ, 32'hb);
		wr(ADDR_COMM, 32'h0);
		cyc(2);
		chk(motor_stop, 1'b0);
		$display("test timeout done");
		stop_test();
	end
endmodule : tb
bind smcs_top smcs_chk #(.REPLY_CYCLES(REPLY_CYCLES)) i_chk (.clk_sys, .rst_n, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .lsp_hit, .lsn_hit, .frame_ok, .reply_go,
	.reply_cksum, .rs485_en, .rs232_en, .droop_clear, .droop_drain, .motor_stop, .mon1_mv,
	.mon2_mv);
`default_nettype wire
